// File: logic/pewc_pkg.sv
`default_nettype none
package pewc_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1_000_000;
    localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_UNIT_MS  = 16;
    localparam int SLEEP_UNIT_MS = 1000;
    localparam int CNT_W         = 18;
    typedef logic [CNT_W-1:0] pewc_cnt_t;

    // Register map
    localparam logic [7:0] ADDR_CTRL   = 8'hd4;
    localparam logic [7:0] ADDR_TIMING = 8'hd6;
    localparam logic [7:0] ADDR_GRR    = 8'h26;
    localparam logic [7:0] ADDR_PSTAT  = 8'hf0;

    // Control register fields
    localparam int BIT_DELAY_EN  = 14;
    localparam int BIT_RSV13     = 13;
    localparam int BIT_POL       = 12;
    localparam int EN_LSB        = 8;
    localparam int BIT_AUTO      = 7;
    localparam int BIT_TO_NORMAL = 6;
    localparam int EVT_LSB       = 2;
    localparam int MODE_LSB      = 0;

    // Timing register fields
    localparam int WAKE_LSB  = 8;
    localparam int SLEEP_LSB = 0;
    localparam logic [7:0] WAKE_RESET  = 8'h08;
    localparam logic [7:0] SLEEP_RESET = 8'h0c;

    // Wake event codes
    localparam logic [3:0] EVT_NONE   = 4'h0;
    localparam logic [3:0] EVT_ENERGY = 4'h1;
    localparam logic [3:0] EVT_LINK   = 4'h2;
    localparam logic [3:0] EVT_MAGIC  = 4'h4;
    localparam logic [3:0] EVT_FRAME  = 4'h8;

    typedef enum logic [1:0] {
        MODE_NORMAL    = 2'h0,
        MODE_ENERGY    = 2'h1,
        MODE_SOFT_DOWN = 2'h2,
        MODE_SAVING    = 2'h3
    } pewc_mode_t;

    typedef enum logic [4:0] {
        ST_NORMAL    = 5'h01,
        ST_ED_AWAKE  = 5'h02,
        ST_ED_LOW    = 5'h04,
        ST_SOFT_DOWN = 5'h08,
        ST_SAVING    = 5'h10
    } pewc_state_t;
endpackage : pewc_pkg
`default_nettype wire

// File: logic/pewc_tick.sv
`timescale 1ns/100ps
`default_nettype none
module pewc_tick #(
    parameter int P_DIV = 100000
) (
    input  wire logic i_clock,
    input  wire logic i_srst,
    output logic      o_tick
);
    localparam int W = $clog2(P_DIV + 1);
    localparam logic [W-1:0] LAST = W'(P_DIV - 1);

    logic [W-1:0] count;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (count == LAST);
            if (count == LAST) begin
                count <= '0;
            end else begin
                count <= count + W'(1);
            end
        end
    end
endmodule : pewc_tick
`default_nettype wire

// File: logic/pewc_top.sv
// Contract
// - Energy wake recorded as code 0001, link-up wake as 0010; 0000 means none.
// - Magic packet wake recorded as code 0100, wake frame as 1000.
// - Energy wake also sets interrupt status bit 2; link-up wake sets bit 3.
// - Event bits 5-2 read-only, cleared by writing 1, cleared at power-up reset.
// - Clearing the event bits deasserts the event output pin.
// - Mode field bits 1-0: normal, energy detect, soft down, saving; resets to 00.
// - Energy detect mode has a low power and a normal power state.
// - Low power state wakes on line energy or host read of global reset register.
// - Soft power down wakes only on host read of global reset register.
// - Wake time bits 15-8 set minimum continuous energy period, 16 ms units.
// - Wake time resets to 0x08, 128 ms.
// - Sleep time bits 7-0 set minimum continuous no-energy period, 1 s units.
// - Sleep time resets to 0x0C, 12 seconds.
// - Polarity bit 1 makes the event output active high, 0 active low.
// - Enable bits 11..8 map to wake frame, magic packet, link up, energy.
// - Energy wake from low power happens only with auto wake-up bit 7 set.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module pewc_top #(
    parameter int P_CYCLES_PER_MS = pewc_pkg::CYCLES_PER_MS
) (
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic        i_cfg_reset,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_energy_detect,
    input  wire logic        i_link_up_event,
    input  wire logic        i_magic_event,
    input  wire logic        i_frame_event,
    input  wire logic        i_clocks_ready,
    output logic             o_power_event_output,
    output logic             o_isr_energy_set,
    output logic             o_isr_link_set,
    output logic             o_low_power,
    output logic             o_power_saving
);
    typedef struct packed {
        logic                  energy_meta;
        logic                  energy_sync;
        logic                  energy_prev;
        logic [3:0]            wake_status;
        logic                  delay_en;
        logic                  rsv13;
        logic                  polarity;
        logic [3:0]            out_enable;
        logic                  auto_wake;
        logic                  to_normal;
        pewc_pkg::pewc_mode_t  mode;
        logic [7:0]            wake_time;
        logic [7:0]            sleep_time;
        pewc_pkg::pewc_state_t pstate;
        pewc_pkg::pewc_cnt_t   dur_count;
        logic [15:0]           rdata;
        logic                  power_event_output;
        logic                  isr_energy;
        logic                  isr_link;
        logic                  low_power;
        logic                  saving;
    } pewc_regs_t;

    localparam pewc_pkg::pewc_cnt_t CNT_MAX = '1;

    pewc_regs_t r;
    pewc_regs_t next_r;
    logic       tick_ms;

    pewc_tick #(
        .P_DIV (P_CYCLES_PER_MS)
    ) u_tick (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .o_tick  (tick_ms)
    );

    always_comb begin
        logic                  wr_ctrl;
        logic                  wr_timing;
        logic                  host_wake;
        logic [3:0]            evt_set;
        logic [3:0]            evt_clr;
        logic                  energy_wake;
        logic                  pme_active;
        logic                  pme_hold;
        pewc_pkg::pewc_cnt_t   wake_thr;
        pewc_pkg::pewc_cnt_t   sleep_thr;
        pewc_pkg::pewc_state_t want;

        next_r      = r;
        wr_ctrl     = i_wr && (i_addr == pewc_pkg::ADDR_CTRL);
        wr_timing   = i_wr && (i_addr == pewc_pkg::ADDR_TIMING);
        host_wake   = i_rd && (i_addr == pewc_pkg::ADDR_GRR);
        evt_set     = pewc_pkg::EVT_NONE;
        evt_clr     = pewc_pkg::EVT_NONE;
        energy_wake = 1'b0;
        want        = r.pstate;
        // Product fits: 255 * 1000 stays below the counter ceiling
        wake_thr  = pewc_pkg::pewc_cnt_t'(r.wake_time)
                  * pewc_pkg::pewc_cnt_t'(pewc_pkg::WAKE_UNIT_MS);
        sleep_thr = pewc_pkg::pewc_cnt_t'(r.sleep_time)
                  * pewc_pkg::pewc_cnt_t'(pewc_pkg::SLEEP_UNIT_MS);

        // Pin synchroniser
        next_r.energy_meta = i_energy_detect;
        next_r.energy_sync = r.energy_meta;
        next_r.energy_prev = r.energy_sync;

        // Register writes
        if (wr_ctrl) begin
            next_r.delay_en   = i_wdata[pewc_pkg::BIT_DELAY_EN];
            next_r.rsv13      = i_wdata[pewc_pkg::BIT_RSV13];
            next_r.polarity   = i_wdata[pewc_pkg::BIT_POL];
            next_r.out_enable = i_wdata[pewc_pkg::EN_LSB +: 4];
            next_r.auto_wake  = i_wdata[pewc_pkg::BIT_AUTO];
            next_r.to_normal  = i_wdata[pewc_pkg::BIT_TO_NORMAL];
            next_r.mode       = pewc_pkg::pewc_mode_t'(i_wdata[pewc_pkg::MODE_LSB +: 2]);
            evt_clr           = i_wdata[pewc_pkg::EVT_LSB +: 4];
        end
        // Zero is never written here, so a zero threshold is not guarded
        if (wr_timing) begin
            next_r.wake_time  = i_wdata[pewc_pkg::WAKE_LSB +: 8];
            next_r.sleep_time = i_wdata[pewc_pkg::SLEEP_LSB +: 8];
        end

        // Duration counter, restarted on any break in the sensed level
        if ((r.energy_sync != r.energy_prev)
            || !((r.pstate == pewc_pkg::ST_ED_AWAKE) || (r.pstate == pewc_pkg::ST_ED_LOW))) begin
            next_r.dur_count = '0;
        end else if (tick_ms && (r.dur_count != CNT_MAX)) begin
            next_r.dur_count = r.dur_count + pewc_pkg::pewc_cnt_t'(1);
        end

        // Power state
        case (r.pstate)
            pewc_pkg::ST_ED_LOW: begin
                if (host_wake) begin
                    want = pewc_pkg::ST_NORMAL;
                    next_r.mode = pewc_pkg::MODE_NORMAL;
                end else if (r.auto_wake && r.energy_sync
                             && (r.dur_count >= wake_thr)) begin
                    energy_wake = 1'b1;
                    want = pewc_pkg::ST_ED_AWAKE;
                    if (r.to_normal) begin
                        want = pewc_pkg::ST_NORMAL;
                        next_r.mode = pewc_pkg::MODE_NORMAL;
                    end
                end
            end
            pewc_pkg::ST_ED_AWAKE: begin
                if (!r.energy_sync && (r.dur_count >= sleep_thr)) begin
                    want = pewc_pkg::ST_ED_LOW;
                end
            end
            pewc_pkg::ST_SOFT_DOWN: begin
                // Line energy is ignored here; only the host brings it back
                if (host_wake) begin
                    want = pewc_pkg::ST_NORMAL;
                    next_r.mode = pewc_pkg::MODE_NORMAL;
                end
            end
            pewc_pkg::ST_NORMAL,
            pewc_pkg::ST_SAVING: begin
                want = r.pstate;
            end
            default: begin
                want = pewc_pkg::ST_NORMAL;
            end
        endcase

        // State follows the mode field whenever they disagree
        case (next_r.mode)
            pewc_pkg::MODE_ENERGY: begin
                if ((want != pewc_pkg::ST_ED_AWAKE) && (want != pewc_pkg::ST_ED_LOW)) begin
                    want = pewc_pkg::ST_ED_AWAKE;
                end
            end
            pewc_pkg::MODE_SOFT_DOWN: begin
                want = pewc_pkg::ST_SOFT_DOWN;
            end
            pewc_pkg::MODE_SAVING: begin
                want = pewc_pkg::ST_SAVING;
            end
            default: begin
                want = pewc_pkg::ST_NORMAL;
            end
        endcase
        next_r.pstate = want;
        if (want != r.pstate) begin
            next_r.dur_count = '0;
        end

        // Wake event capture
        if (energy_wake) begin
            evt_set = evt_set | pewc_pkg::EVT_ENERGY;
        end
        if (i_link_up_event) begin
            evt_set = evt_set | pewc_pkg::EVT_LINK;
        end
        if (i_magic_event) begin
            evt_set = evt_set | pewc_pkg::EVT_MAGIC;
        end
        if (i_frame_event) begin
            evt_set = evt_set | pewc_pkg::EVT_FRAME;
        end
        // A new event beats a clear in the same cycle
        next_r.wake_status = (r.wake_status & ~evt_clr) | evt_set;
        next_r.isr_energy  = energy_wake;
        next_r.isr_link    = i_link_up_event;

        // Event output: enable bit order equals the event code bit order
        pme_active = |(next_r.wake_status & next_r.out_enable);
        pme_hold   = next_r.delay_en && next_r.auto_wake && !i_clocks_ready;
        next_r.power_event_output = (pme_active && !pme_hold) ? next_r.polarity : !next_r.polarity;

        next_r.low_power = (want == pewc_pkg::ST_ED_LOW) || (want == pewc_pkg::ST_SOFT_DOWN);
        next_r.saving    = (want == pewc_pkg::ST_SAVING);

        // Read data, valid the cycle after the strobe only
        next_r.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                pewc_pkg::ADDR_CTRL: begin
                    next_r.rdata[pewc_pkg::BIT_DELAY_EN]  = r.delay_en;
                    next_r.rdata[pewc_pkg::BIT_RSV13]     = r.rsv13;
                    next_r.rdata[pewc_pkg::BIT_POL]       = r.polarity;
                    next_r.rdata[pewc_pkg::EN_LSB +: 4]   = r.out_enable;
                    next_r.rdata[pewc_pkg::BIT_AUTO]      = r.auto_wake;
                    next_r.rdata[pewc_pkg::BIT_TO_NORMAL] = r.to_normal;
                    next_r.rdata[pewc_pkg::EVT_LSB +: 4]  = r.wake_status;
                    next_r.rdata[pewc_pkg::MODE_LSB +: 2] = r.mode;
                end
                pewc_pkg::ADDR_TIMING: begin
                    next_r.rdata[pewc_pkg::WAKE_LSB +: 8]  = r.wake_time;
                    next_r.rdata[pewc_pkg::SLEEP_LSB +: 8] = r.sleep_time;
                end
                pewc_pkg::ADDR_PSTAT: begin
                    next_r.rdata[4:0] = r.pstate;
                    next_r.rdata[5]   = r.energy_sync;
                end
                default: begin
                    next_r.rdata = 16'h0000;
                end
            endcase
        end

        // Hardware or software reset: configuration only, events are kept
        if (i_cfg_reset) begin
            next_r.delay_en   = 1'b0;
            next_r.rsv13      = 1'b0;
            next_r.polarity   = 1'b0;
            next_r.out_enable = 4'h0;
            next_r.auto_wake  = 1'b0;
            next_r.to_normal  = 1'b0;
            next_r.mode       = pewc_pkg::MODE_NORMAL;
            next_r.wake_time  = pewc_pkg::WAKE_RESET;
            next_r.sleep_time = pewc_pkg::SLEEP_RESET;
            next_r.pstate     = pewc_pkg::ST_NORMAL;
            next_r.dur_count  = '0;
            next_r.low_power  = 1'b0;
            next_r.saving     = 1'b0;
            next_r.power_event_output        = (|(next_r.wake_status & 4'h0)) ? 1'b0 : 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            r.energy_meta <= 1'b0;
            r.energy_sync <= 1'b0;
            r.energy_prev <= 1'b0;
            r.wake_status <= pewc_pkg::EVT_NONE;
            r.delay_en    <= 1'b0;
            r.rsv13       <= 1'b0;
            r.polarity    <= 1'b0;
            r.out_enable  <= 4'h0;
            r.auto_wake   <= 1'b0;
            r.to_normal   <= 1'b0;
            r.mode        <= pewc_pkg::MODE_NORMAL;
            r.wake_time   <= pewc_pkg::WAKE_RESET;
            r.sleep_time  <= pewc_pkg::SLEEP_RESET;
            r.pstate      <= pewc_pkg::ST_NORMAL;
            r.dur_count   <= '0;
            r.rdata       <= 16'h0000;
            r.power_event_output         <= 1'b1;
            r.isr_energy  <= 1'b0;
            r.isr_link    <= 1'b0;
            r.low_power   <= 1'b0;
            r.saving      <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign o_rdata              = r.rdata;
    assign o_power_event_output = r.power_event_output;
    assign o_isr_energy_set     = r.isr_energy;
    assign o_isr_link_set       = r.isr_link;
    assign o_low_power          = r.low_power;
    assign o_power_saving       = r.saving;
endmodule : pewc_top
`default_nettype wire

// File: testbench/pewc_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pewc_top_properties #(
    parameter int P_CYCLES_PER_MS = pewc_pkg::CYCLES_PER_MS
) (
    input wire logic        i_clock,
    input wire logic        i_srst,
    input wire logic        i_cfg_reset,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        i_energy_detect,
    input wire logic        i_link_up_event,
    input wire logic        i_magic_event,
    input wire logic        i_frame_event,
    input wire logic        i_clocks_ready,
    input wire logic        o_power_event_output,
    input wire logic        o_isr_energy_set,
    input wire logic        o_isr_link_set,
    input wire logic        o_low_power,
    input wire logic        o_power_saving
);
    // Shadow of the control word, so enables and polarity are known here
    logic [15:0] sh;
    wire         ctrl_wr = i_wr && i_addr == pewc_pkg::ADDR_CTRL;
    wire         grr_rd  = i_rd && i_addr == pewc_pkg::ADDR_GRR;
    wire         hit     = i_link_up_event && sh[9] || i_magic_event && sh[10] || i_frame_event && sh[11];
    wire         any_ev  = i_link_up_event || i_magic_event || i_frame_event;
    always_ff @(posedge i_clock) begin
        if (i_srst || i_cfg_reset) sh <= 16'h0000;
        else if (ctrl_wr) sh <= i_wdata;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst || i_cfg_reset);
    property p_link_isr; i_link_up_event |=> o_isr_link_set; endproperty
    a_link_isr: assert property (p_link_isr) else $error("link event gave no status pulse");
    property p_isr_cause; o_isr_link_set |-> $past(i_link_up_event); endproperty
    a_isr_cause: assert property (p_isr_cause) else $error("link status pulse without event");
    property p_energy_pulse; o_isr_energy_set |=> !o_isr_energy_set; endproperty
    a_energy_pulse: assert property (p_energy_pulse) else $error("energy status pulse too long");
    property p_event_pme; hit && !i_wr && !(sh[14] && sh[7] && !i_clocks_ready) |=> o_power_event_output == sh[12]; endproperty
    a_event_pme: assert property (p_event_pme) else $error("enabled event did not drive output");
    property p_clear_pme; ctrl_wr && i_wdata[5:2] == 4'hf && !any_ev |=> o_isr_energy_set || o_power_event_output == !$past(i_wdata[12]); endproperty
    a_clear_pme: assert property (p_clear_pme) else $error("output active after clearing events");
    property p_mode_saving; ctrl_wr |=> o_power_saving == &$past(i_wdata[1:0]); endproperty
    a_mode_saving: assert property (p_mode_saving) else $error("saving flag does not follow mode");
    property p_soft_down; ctrl_wr && i_wdata[1:0] == 2'h2 |=> o_low_power; endproperty
    a_soft_down: assert property (p_soft_down) else $error("soft power down not low power");
    property p_grr_wake; o_low_power && grr_rd |=> !o_low_power; endproperty
    a_grr_wake: assert property (p_grr_wake) else $error("host read did not wake");
    property p_no_autowake; o_low_power && !sh[7] && !grr_rd && !ctrl_wr |=> o_low_power; endproperty
    a_no_autowake: assert property (p_no_autowake) else $error("woke without auto wake or host read");
endmodule : pewc_top_properties
bind pewc_top pewc_top_properties #(.P_CYCLES_PER_MS(P_CYCLES_PER_MS)) pewc_top_properties_i (
    .i_clock(i_clock), .i_srst(i_srst), .i_cfg_reset(i_cfg_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_energy_detect(i_energy_detect),
    .i_link_up_event(i_link_up_event), .i_magic_event(i_magic_event), .i_frame_event(i_frame_event),
    .i_clocks_ready(i_clocks_ready), .o_power_event_output(o_power_event_output),
    .o_isr_energy_set(o_isr_energy_set), .o_isr_link_set(o_isr_link_set), .o_low_power(o_low_power),
    .o_power_saving(o_power_saving)
);
`default_nettype wire

// File: testbench/pewc_host.sv
`timescale 1ns/100ps
`default_nettype none
module pewc_host (
    input  wire logic        i_clock,
    input  wire logic [15:0] i_rdata,
    output var  logic [7:0]  o_addr,
    output var  logic [15:0] o_wdata,
    output var  logic        o_wr,
    output var  logic        o_rd
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 16'h0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        // Software never programs a zero time
        if (a == pewc_pkg::ADDR_TIMING && (d[15:8] == 8'h00 || d[7:0] == 8'h00)) return;
        @(posedge i_clock);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : bus_read
    task automatic host_wake();
        logic [15:0] v;
        bus_read(pewc_pkg::ADDR_GRR, v);
    endtask : host_wake
endmodule : pewc_host
`default_nettype wire

// File: testbench/power_event_wake_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module power_event_wake_control_test;
    localparam int P_MS = 2;
    logic        clk, srst, cfg_rst, wr, rd, energy, power_event_output, isr_e, isr_l, low, sav;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic [3:0]  ev;
    int          err_count, check_count, cycles, n, seed, ctrl, pol, seen;
    pewc_top #(.P_CYCLES_PER_MS(P_MS)) pewc_top_i (
        .i_clock(clk), .i_srst(srst), .i_cfg_reset(cfg_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_energy_detect(energy), .i_link_up_event(ev[1]), .i_magic_event(ev[2]),
        .i_frame_event(ev[3]), .i_clocks_ready(1'b1), .o_power_event_output(power_event_output), .o_isr_energy_set(isr_e),
        .o_isr_link_set(isr_l), .o_low_power(low), .o_power_saving(sav)
    );
    pewc_host pewc_host_i (
        .i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
    );
    task automatic conclude();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk16
    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk1
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        pewc_host_i.bus_read(a, v);
        chk16(v, e);
    endtask : rdchk
    task automatic pulse(input int k);
        @(posedge clk) ev[k] <= 1'b1;
        @(posedge clk) ev[k] <= 1'b0;
        #1;
    endtask : pulse
    // Counts edges until the low power flag reaches lvl, noting energy pulses
    task automatic wait_low(input logic lvl, input int lim);
        n = 0;
        seen = 0;
        while (low !== lvl && n < lim) begin
            @(posedge clk);
            #1;
            seen = seen | isr_e;
            n++;
        end
    endtask : wait_low
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        seed = 32'h14fca0da;
        srst = 1'b1;
        cfg_rst = 1'b0;
        energy = 1'b0;
        ev = 4'h0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk1(power_event_output, 1'b1);
        rdchk(pewc_pkg::ADDR_CTRL, 16'h0000);
        rdchk(pewc_pkg::ADDR_TIMING, 16'h080c);
        pewc_host_i.bus_write(8'h40, 16'hffff);
        rdchk(8'h40, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            d = 16'($random(seed)) | 16'h0101;
            pewc_host_i.bus_write(pewc_pkg::ADDR_TIMING, d);
            rdchk(pewc_pkg::ADDR_TIMING, d);
        end
        for (int m = 0; m < 4; m++) begin
            pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'(m));
            #1;
            chk1(low, m == 2);
            chk1(sav, m == 3);
            rdchk(pewc_pkg::ADDR_CTRL, 16'(m));
        end
        for (int k = 1; k < 4; k++) begin
            pol = $random(seed) & 1;
            ctrl = (pol << 12) | (1 << (k + 8));
            pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'(ctrl));
            pulse(k);
            chk1(power_event_output, pol[0]);
            chk1(isr_l, k == 1);
            rdchk(pewc_pkg::ADDR_CTRL, 16'(ctrl | (1 << (k + 2))));
            @(posedge clk) cfg_rst <= 1'b1;
            @(posedge clk) cfg_rst <= 1'b0;
            rdchk(pewc_pkg::ADDR_CTRL, 16'(1 << (k + 2)));
            pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'(ctrl | 32'h3c));
            #1;
            chk1(power_event_output, !pol[0]);
            rdchk(pewc_pkg::ADDR_CTRL, 16'(ctrl));
        end
        pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'h1000);
        pulse(2);
        chk1(power_event_output, 1'b0);
        rdchk(pewc_pkg::ADDR_CTRL, 16'h1010);
        // Clear the magic event too, so later control reads start clean
        pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'h0012);
        @(posedge clk) energy <= 1'b1;
        repeat (100) @(posedge clk);
        #1;
        chk1(low, 1'b1);
        pewc_host_i.host_wake();
        chk1(low, 1'b0);
        rdchk(pewc_pkg::ADDR_CTRL, 16'h0000);
        pewc_host_i.bus_write(pewc_pkg::ADDR_TIMING, 16'h0201);
        @(posedge clk) energy <= 1'b0;
        ctrl = 16'h1181;
        pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'(ctrl));
        wait_low(1'b1, 2200);
        chk1(n >= 1994 && n <= 2010, 1'b1);
        @(posedge clk) energy <= 1'b1;
        repeat (40) @(posedge clk);
        energy <= 1'b0;
        repeat (4) @(posedge clk);
        energy <= 1'b1;
        #1;
        wait_low(1'b0, 200);
        chk1(n >= 62 && n <= 72, 1'b1);
        chk1(seen[0], 1'b1);
        chk1(power_event_output, 1'b1);
        rdchk(pewc_pkg::ADDR_CTRL, 16'(ctrl | 4));
        pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'(ctrl | 4));
        #1;
        chk1(power_event_output, 1'b0);
        @(posedge clk) energy <= 1'b0;
        pewc_host_i.bus_write(pewc_pkg::ADDR_CTRL, 16'h1101);
        wait_low(1'b1, 2200);
        chk1(n >= 1994 && n <= 2010, 1'b1);
        @(posedge clk) energy <= 1'b1;
        repeat (200) @(posedge clk);
        #1;
        chk1(low, 1'b1);
        pewc_host_i.host_wake();
        chk1(low, 1'b0);
        rdchk(pewc_pkg::ADDR_CTRL, 16'h1100);
        conclude();
    end
endmodule : power_event_wake_control_test
`default_nettype wire
